/* File: src/card_file_cmd.sv */
// Card-side interpreter of status, binary and record file commands.
// Functional notes
// - Status needs both parameter bytes zero; reply carries directory info like a select.
// - Binary read only on transparent file with read access met; returns body bytes.
// - Binary read or write on a non-transparent file is aborted.
// - First byte bit 8 clear: its low seven bits are offset high, second byte low.
// - First byte top bits 100: low five bits are the file id, second byte offset.
// - Binary read carries no data field; response length gives the count returned.
// - Binary write overwrites bytes from the offset, needs update access, returns nothing.
// - Binary write decodes offset and file id exactly like the binary read.
// - Record read returns one whole record with read access; failure keeps pointer.
// - Current and absolute modes access pointed or numbered record, pointer untouched.
// - Next mode increments pointer first; an unset pointer goes to the first record.
// - Linear file, pointer on last record: next read keeps pointer, returns nothing.
// - Cyclic file, pointer on last record: next read wraps to first and returns it.
// - Previous mode decrements pointer first; an unset pointer goes to the last record.
// - Pointer on first record: previous wraps to last if cyclic, else fails unchanged.
// - Record file reference bits zero mean current file, else a file id 1 to 30.
// - Low mode bits 010 next, 011 previous, 100 absolute; record number zero is current.
// - Record number byte is ignored for next and previous modes.
// - Record update needs update access; cyclic files take previous only; failure keeps pointer.
// - Cyclic previous update writes oldest record, points there, and makes it record one.
// - Linear next and previous updates move the pointer like reads; boundary writes nothing.
`timescale 1ns/100ps
`default_nettype none
module card_file_cmd (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic                   cmd_valid,
	input  wire card_cmd_pkg::op_t      cmd_op,
	input  wire logic [7:0]             cmd_p1,
	input  wire logic [7:0]             cmd_p2,
	input  wire logic [7:0]             cmd_le,
	input  wire logic                   file_selected,
	input  wire card_cmd_pkg::fstruct_t file_struct,
	input  wire logic [7:0]             file_rec_count,
	input  wire logic [7:0]             file_rec_len,
	input  wire logic                   read_access_ok,
	input  wire logic                   update_access_ok,
	output logic                        resp_valid,
	output card_cmd_pkg::result_t       resp_result,
	output logic [7:0]                  resp_len,
	output logic                        resp_dir_info,
	output logic                        mem_read,
	output logic                        mem_write,
	output logic [14:0]                 mem_offset,
	output logic [7:0]                  mem_record,
	output logic                        ref_sfi_used,
	output logic [4:0]                  ref_sfi,
	output logic [7:0]                  rec_pointer,
	output logic                        rec_pointer_set
);
	import card_cmd_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0]  ptr;
		logic        ptr_set;
		logic [7:0]  head;
		logic        valid;
		result_t     result;
		logic [7:0]  len;
		logic        dir_info;
		logic        rd;
		logic        wr;
		logic [14:0] offset;
		logic [7:0]  record;
		logic        sfi_used;
		logic [4:0]  sfi;
	} state_t;

	state_t st;
	state_t next_st;

	card_param_if pif ();
	assign pif.p1 = cmd_p1;
	assign pif.p2 = cmd_p2;

	card_param_dec u_dec (
		.pif (pif.dec)
	);

	// ==========================================================
	// Record number to physical slot. In a cyclic file record one is the
	// newest, held at head; numbering advances towards older data.
	function automatic logic [7:0] to_slot(input logic [7:0] rec, input logic [7:0] head,
		input logic [7:0] count, input logic cyclic);
		logic [8:0] sum;
		sum = {1'b0, head} + {1'b0, rec} - 9'h001;
		if (!cyclic)
			return rec - FIRST_REC;
		if (sum >= {1'b0, count})
			sum = sum - {1'b0, count};
		return sum[7:0];
	endfunction

	logic       is_cyclic;
	logic       is_record;
	logic [7:0] cur_ptr;
	logic       cur_set;
	logic [7:0] target;
	logic       tgt_ok;
	logic       moves;
	logic [7:0] oldest;

	always_comb begin
		is_cyclic = (file_struct == FS_CYCLIC);
		is_record = (file_struct == FS_LINEAR) || is_cyclic;
		// A short file reference switches the current file, so its pointer starts unset.
		cur_set   = st.ptr_set && !pif.rec_sfi_used;
		cur_ptr   = st.ptr;
		oldest    = (st.head == HEAD_RESET) ? file_rec_count - FIRST_REC : st.head - FIRST_REC;
		target    = cur_ptr;
		tgt_ok    = 1'b1;
		moves     = 1'b0;
		unique case (pif.rec_mode)
			RM_NEXT: begin
				moves = 1'b1;
				if (!cur_set) begin
					target = FIRST_REC;
				end else if (cur_ptr >= file_rec_count) begin
					target = FIRST_REC;
					tgt_ok = is_cyclic;
				end else begin
					target = cur_ptr + FIRST_REC;
				end
			end
			RM_PREV: begin
				moves = 1'b1;
				if (!cur_set) begin
					target = file_rec_count;
				end else if (cur_ptr <= FIRST_REC) begin
					target = file_rec_count;
					tgt_ok = is_cyclic;
				end else begin
					target = cur_ptr - FIRST_REC;
				end
			end
			RM_ABS: begin
				if (cmd_p1 == P1_CURRENT_REC) begin
					tgt_ok = cur_set;
				end else begin
					target = cmd_p1;
					tgt_ok = (cmd_p1 <= file_rec_count);
				end
			end
			RM_BAD: begin
				tgt_ok = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Command execution, one command per cycle, answer one cycle later
	always_comb begin
		next_st          = st;
		next_st.valid    = 1'b0;
		next_st.rd       = 1'b0;
		next_st.wr       = 1'b0;
		next_st.dir_info = 1'b0;
		if (file_selected) begin
			next_st.ptr_set = 1'b0;
			next_st.ptr     = PTR_RESET;
		end
		if (cmd_valid) begin
			next_st.valid    = 1'b1;
			next_st.result   = RES_OK;
			next_st.len      = 8'h00;
			next_st.sfi_used = 1'b0;
			next_st.sfi      = pif.sfi;
			unique case (cmd_op)
				OP_STATUS: begin
					if (cmd_p1 != STATUS_P_VALUE || cmd_p2 != STATUS_P_VALUE) begin
						next_st.result = RES_BAD_PARAM;
					end else begin
						next_st.dir_info = 1'b1;
						next_st.len      = cmd_le;
					end
				end
				OP_READ_BIN, OP_UPDATE_BIN: begin
					next_st.sfi_used = pif.bin_sfi_used;
					next_st.offset   = pif.bin_offset;
					if (!pif.bin_ok) begin
						next_st.result = RES_BAD_PARAM;
					end else if (file_struct != FS_TRANSPARENT) begin
						next_st.result = RES_WRONG_STRUCT;
					end else if (cmd_op == OP_READ_BIN) begin
						if (!read_access_ok) begin
							next_st.result = RES_DENIED;
						end else begin
							next_st.rd  = 1'b1;
							next_st.len = cmd_le;
						end
					end else if (!update_access_ok) begin
						next_st.result = RES_DENIED;
					end else begin
						next_st.wr = 1'b1;
					end
				end
				OP_READ_REC, OP_UPDATE_REC: begin
					next_st.sfi_used = pif.rec_sfi_used;
					next_st.sfi      = pif.p2[7:3];
					if (pif.rec_sfi_bad || pif.rec_mode == RM_BAD) begin
						next_st.result = RES_BAD_PARAM;
					end else if (!is_record) begin
						next_st.result = RES_WRONG_STRUCT;
					end else if (cmd_op == OP_READ_REC) begin
						if (!read_access_ok) begin
							next_st.result = RES_DENIED;
						end else if (!tgt_ok) begin
							next_st.result = RES_NO_RECORD;
						end else begin
							next_st.rd     = 1'b1;
							next_st.len    = file_rec_len;
							next_st.record = to_slot(target, st.head, file_rec_count, is_cyclic);
							if (moves) begin
								next_st.ptr     = target;
								next_st.ptr_set = 1'b1;
							end
						end
					end else if (!update_access_ok) begin
						next_st.result = RES_DENIED;
					end else if (is_cyclic) begin
						if (pif.rec_mode != RM_PREV) begin
							next_st.result = RES_NOT_ALLOWED;
						end else begin
							next_st.wr      = 1'b1;
							next_st.record  = oldest;
							next_st.head    = oldest;
							next_st.ptr     = FIRST_REC;
							next_st.ptr_set = 1'b1;
						end
					end else if (!tgt_ok) begin
						next_st.result = RES_NO_RECORD;
					end else begin
						next_st.wr     = 1'b1;
						next_st.record = to_slot(target, st.head, file_rec_count, 1'b0);
						if (moves) begin
							next_st.ptr     = target;
							next_st.ptr_set = 1'b1;
						end
					end
				end
				default: begin
					next_st.result = RES_BAD_PARAM;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '{ptr: PTR_RESET, ptr_set: 1'b0, head: HEAD_RESET, valid: 1'b0,
				result: RES_OK, len: 8'h00, dir_info: 1'b0, rd: 1'b0, wr: 1'b0,
				offset: 15'h0000, record: 8'h00, sfi_used: 1'b0, sfi: 5'h00};
		end else begin
			st <= next_st;
		end
	end

	assign resp_valid      = st.valid;
	assign resp_result     = st.result;
	assign resp_len        = st.len;
	assign resp_dir_info   = st.dir_info;
	assign mem_read        = st.rd;
	assign mem_write       = st.wr;
	assign mem_offset      = st.offset;
	assign mem_record      = st.record;
	assign ref_sfi_used    = st.sfi_used;
	assign ref_sfi         = st.sfi;
	assign rec_pointer     = st.ptr;
	assign rec_pointer_set = st.ptr_set;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_status_reply: assert property (cmd_valid && cmd_op == OP_STATUS && cmd_p1 == 8'h00 &&
		cmd_p2 == 8'h00 |=> resp_dir_info && resp_len == $past(cmd_le))
		else $error("status did not answer with directory info");
	a_bin_struct: assert property (cmd_valid && cmd_op inside {OP_READ_BIN, OP_UPDATE_BIN} &&
		file_struct != FS_TRANSPARENT |=> resp_result != RES_OK && !mem_read && !mem_write)
		else $error("binary access on non-transparent file not aborted");
	a_bin_offset: assert property (cmd_valid && cmd_op == OP_READ_BIN && !cmd_p1[7] &&
		file_struct == FS_TRANSPARENT |=> mem_offset == {$past(cmd_p1[6:0]), $past(cmd_p2)})
		else $error("binary offset decode wrong");
	a_bin_sfi: assert property (cmd_valid && cmd_op == OP_UPDATE_BIN && cmd_p1[7:5] == 3'h4
		|=> ref_sfi_used && ref_sfi == $past(cmd_p1[4:0]) && mem_offset == {7'h00, $past(cmd_p2)})
		else $error("short file reference decode wrong");
	a_read_denied: assert property (cmd_valid && cmd_op inside {OP_READ_BIN, OP_READ_REC} &&
		!read_access_ok && !file_selected |=> !mem_read && $stable(rec_pointer))
		else $error("read performed without access or moved pointer");
	a_abs_keeps: assert property (cmd_valid && cmd_op == OP_READ_REC && cmd_p2[2:0] == 3'h4
		&& !file_selected |=> $stable(rec_pointer) && $stable(rec_pointer_set))
		else $error("absolute or current read moved pointer");
	a_next_unset: assert property (cmd_valid && cmd_op == OP_READ_REC && !rec_pointer_set
		&& cmd_p2 == 8'h02 && file_struct == FS_LINEAR && read_access_ok
		&& file_rec_count != 8'h00 |=> rec_pointer == 8'h01 && mem_read)
		else $error("next read from unset pointer not at first record");
	a_lin_last: assert property (cmd_valid && cmd_op == OP_READ_REC && rec_pointer_set &&
		cmd_p2 == 8'h02 && file_struct == FS_LINEAR && rec_pointer == file_rec_count
		&& !file_selected |=> !mem_read && $stable(rec_pointer))
		else $error("linear next read past last record");
	a_cyc_wrap: assert property (cmd_valid && cmd_op == OP_READ_REC && rec_pointer_set &&
		cmd_p2 == 8'h02 && file_struct == FS_CYCLIC && rec_pointer == file_rec_count
		&& read_access_ok && !file_selected |=> rec_pointer == 8'h01 && mem_read)
		else $error("cyclic next read did not wrap");
	a_cyc_update: assert property (cmd_valid && cmd_op == OP_UPDATE_REC && update_access_ok &&
		file_struct == FS_CYCLIC && cmd_p2[7:3] == 5'h00 && cmd_p2[2:0] inside {3'h2, 3'h4}
		|=> !mem_write && resp_result == RES_NOT_ALLOWED)
		else $error("cyclic update in a mode other than previous");
	a_cyc_oldest: assert property (cmd_valid && cmd_op == OP_UPDATE_REC && update_access_ok &&
		file_struct == FS_CYCLIC && cmd_p2 == 8'h03 && !file_selected
		|=> mem_write && rec_pointer == 8'h01 && st.head == mem_record
		&& (mem_record + 8'h01 == $past(st.head)
		|| mem_record + 8'h01 == $past(file_rec_count) && $past(st.head) == HEAD_RESET))
		else $error("cyclic update did not point at record one");
endmodule // card_file_cmd
`default_nettype wire

/* File: src/card_cmd_pkg.sv */
// Package of constants and types for the card file access command interpreter.
`default_nettype none
package card_cmd_pkg;
	// ==========================================================
	// Command, structure and result codes
	typedef enum logic [2:0] {
		OP_STATUS, OP_READ_BIN, OP_UPDATE_BIN, OP_READ_REC, OP_UPDATE_REC
	} op_t;
	typedef enum logic [1:0] {
		FS_NONE, FS_TRANSPARENT, FS_LINEAR, FS_CYCLIC
	} fstruct_t;
	typedef enum logic [2:0] {
		RES_OK, RES_BAD_PARAM, RES_WRONG_STRUCT, RES_DENIED, RES_NO_RECORD, RES_NOT_ALLOWED
	} result_t;
	typedef enum logic [1:0] {
		RM_NEXT, RM_PREV, RM_ABS, RM_BAD
	} rmode_t;
	// ==========================================================
	// Parameter byte field positions and codes
	localparam int         P1_MODE_BIT      = 7;
	localparam logic [2:0] P1_SFI_TAG       = 3'h4;
	localparam logic [4:0] SFI_CURRENT      = 5'h00;
	localparam logic [4:0] SFI_RFU          = 5'h1F;
	localparam logic [2:0] P2_MODE_NEXT     = 3'h2;
	localparam logic [2:0] P2_MODE_PREV     = 3'h3;
	localparam logic [2:0] P2_MODE_ABS      = 3'h4;
	localparam logic [7:0] P1_CURRENT_REC   = 8'h00;
	localparam logic [7:0] STATUS_P_VALUE   = 8'h00;
	localparam logic [7:0] FIRST_REC        = 8'h01;
	// ==========================================================
	// Reset values
	localparam logic [7:0] PTR_RESET        = 8'h00;
	localparam logic [7:0] HEAD_RESET       = 8'h00;
endpackage
`default_nettype wire

/* File: src/card_param_if.sv */
// Interface carrying parameter bytes to the decoder and decoded fields back.
`timescale 1ns/100ps
`default_nettype none
interface card_param_if;
	import card_cmd_pkg::*;
	logic [7:0]  p1;
	logic [7:0]  p2;
	logic        bin_ok;
	logic        bin_sfi_used;
	logic [14:0] bin_offset;
	logic [4:0]  sfi;
	logic        rec_sfi_used;
	logic        rec_sfi_bad;
	rmode_t      rec_mode;
	modport dec (input p1, input p2, output bin_ok, output bin_sfi_used, output bin_offset,
		output sfi, output rec_sfi_used, output rec_sfi_bad, output rec_mode);
	modport use_side (output p1, output p2, input bin_ok, input bin_sfi_used, input bin_offset,
		input sfi, input rec_sfi_used, input rec_sfi_bad, input rec_mode);
endinterface
`default_nettype wire

/* File: src/card_param_dec.sv */
// Decoder of the parameter bytes of binary and record commands.
`timescale 1ns/100ps
`default_nettype none
module card_param_dec (
	card_param_if.dec pif
);
	import card_cmd_pkg::*;

	// ==========================================================
	// Binary offset and short file identifier, shared by read and write
	always_comb begin
		pif.bin_ok       = 1'b1;
		pif.bin_sfi_used = 1'b0;
		pif.bin_offset   = {pif.p1[6:0], pif.p2};
		if (pif.p1[P1_MODE_BIT]) begin
			pif.bin_sfi_used = 1'b1;
			pif.bin_offset   = {7'h00, pif.p2};
			pif.bin_ok       = (pif.p1[7:5] == P1_SFI_TAG);
		end
	end

	// ==========================================================
	// Record file reference and mode
	always_comb begin
		pif.sfi          = pif.bin_sfi_used ? pif.p1[4:0] : pif.p2[7:3];
		pif.rec_sfi_used = (pif.p2[7:3] != SFI_CURRENT);
		pif.rec_sfi_bad  = (pif.p2[7:3] == SFI_RFU);
		unique case (pif.p2[2:0])
			P2_MODE_NEXT: pif.rec_mode = RM_NEXT;
			P2_MODE_PREV: pif.rec_mode = RM_PREV;
			P2_MODE_ABS:  pif.rec_mode = RM_ABS;
			default:      pif.rec_mode = RM_BAD;
		endcase
	end
endmodule // card_param_dec
`default_nettype wire

/* File: dv/card_term_model.sv */
// Terminal model that presents command headers to the card interpreter.
`timescale 1ns/100ps
`default_nettype none
module card_term_model (
	output var logic              cmd_valid,
	output var card_cmd_pkg::op_t cmd_op,
	output var logic [7:0]        cmd_p1,
	output var logic [7:0]        cmd_p2,
	output var logic [7:0]        cmd_le
);
	import card_cmd_pkg::*;
	// ==========================================================
	// Header driving
	// A raw header skips the terminal's zeroing of the parameter bytes (Le of an update is
	// still cleared), so that a scenario can present an older or careless terminal on purpose.
	task automatic put(input op_t op, input logic [7:0] p1, input logic [7:0] p2,
		input logic [7:0] le, input logic raw);
		logic rec;
		rec = (op == OP_READ_REC) || (op == OP_UPDATE_REC);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_p1 = (raw || (op != OP_STATUS && !(rec && p2[2:0] inside {P2_MODE_NEXT,
			P2_MODE_PREV}))) ? p1 : STATUS_P_VALUE;
		cmd_p2 = (raw || op != OP_STATUS) ? p2 : STATUS_P_VALUE;
		cmd_le = (op == OP_UPDATE_BIN || op == OP_UPDATE_REC) ? 8'h00 : le;
	endtask
	// Idle header bytes flip so that stale values are never mistaken for a command.
	task automatic idle();
		cmd_valid = 1'b0;
		cmd_p1 = ~cmd_p1;
		cmd_p2 = ~cmd_p2;
		cmd_le = ~cmd_le;
	endtask
	initial begin
		cmd_valid = 1'b0;
		cmd_op = OP_STATUS;
		cmd_p1 = 8'h00;
		cmd_p2 = 8'h00;
		cmd_le = 8'h00;
	end
endmodule // card_term_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the card file access command interpreter.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import card_cmd_pkg::*;
	typedef struct {
		result_t     res;
		logic [7:0]  len;
		logic        rd;
		logic        wr;
		logic        dir;
		logic [14:0] off;
		logic [7:0]  rec;
		logic [7:0]  ptr;
		logic        pset;
		logic        sfu;
		logic [4:0]  sfi;
		logic        bin;
	} exp_t;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	wire logic   cmd_valid;
	wire op_t    cmd_op;
	wire logic [7:0] cmd_p1;
	wire logic [7:0] cmd_p2;
	wire logic [7:0] cmd_le;
	logic        file_selected = 1'b0;
	fstruct_t    file_struct = FS_NONE;
	logic [7:0]  file_rec_count = 8'h01;
	logic [7:0]  file_rec_len = 8'h08;
	logic        read_access_ok = 1'b1;
	logic        update_access_ok = 1'b1;
	logic        resp_valid;
	result_t     resp_result;
	logic [7:0]  resp_len;
	logic        resp_dir_info;
	logic        mem_read;
	logic        mem_write;
	logic [14:0] mem_offset;
	logic [7:0]  mem_record;
	logic        ref_sfi_used;
	logic [4:0]  ref_sfi;
	logic [7:0]  rec_pointer;
	logic        rec_pointer_set;
	exp_t        q[$];
	exp_t        e;
	logic [7:0]  r1;
	logic [7:0]  r2;
	int          num_errors = 0;
	int          n_tests = 0;
	int          cycles = 0;
	always #25 clk = ~clk;
	card_term_model i_card_term_model (.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_p1(cmd_p1),
		.cmd_p2(cmd_p2), .cmd_le(cmd_le));
	card_file_cmd i_card_file_cmd (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_p1(cmd_p1), .cmd_p2(cmd_p2), .cmd_le(cmd_le),
		.file_selected(file_selected), .file_struct(file_struct), .file_rec_count(file_rec_count),
		.file_rec_len(file_rec_len), .read_access_ok(read_access_ok),
		.update_access_ok(update_access_ok), .resp_valid(resp_valid), .resp_result(resp_result),
		.resp_len(resp_len), .resp_dir_info(resp_dir_info), .mem_read(mem_read),
		.mem_write(mem_write), .mem_offset(mem_offset), .mem_record(mem_record),
		.ref_sfi_used(ref_sfi_used), .ref_sfi(ref_sfi), .rec_pointer(rec_pointer),
		.rec_pointer_set(rec_pointer_set));
	// ==========================================================
	// Checking and closing
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			num_errors++;
			close_out();
		end
	end
	// Outputs are sampled at the falling edge, where every flop has settled.
	always @(negedge clk) begin
		if (resp_valid === 1'b1) begin
			if (q.size() == 0) begin
				check("resp_valid", 16'h0001, 16'h0000);
			end else begin
				e = q.pop_front();
				check("resp_result", 16'(resp_result), 16'(e.res));
				check("resp_len", 16'(resp_len), 16'(e.len));
				check("mem_read", 16'(mem_read), 16'(e.rd));
				check("mem_write", 16'(mem_write), 16'(e.wr));
				check("resp_dir_info", 16'(resp_dir_info), 16'(e.dir));
				check("rec_pointer_set", 16'(rec_pointer_set), 16'(e.pset));
				if (e.pset) check("rec_pointer", 16'(rec_pointer), 16'(e.ptr));
				if (e.rd | e.wr) check("ref_sfi_used", 16'(ref_sfi_used), 16'(e.sfu));
				if ((e.rd | e.wr) & e.sfu) check("ref_sfi", 16'(ref_sfi), 16'(e.sfi));
				if ((e.rd | e.wr) & e.bin) check("mem_offset", 16'(mem_offset), 16'(e.off));
				if ((e.rd | e.wr) & !e.bin) check("mem_record", 16'(mem_record), 16'(e.rec));
			end
		end else if (resp_valid === 1'b0) begin
			check("strobes", 16'({mem_read, mem_write, resp_dir_info}), 16'h0000);
		end
	end
	// ==========================================================
	// Drivers
	task automatic set_file(input fstruct_t st, input logic [7:0] cnt, input logic rok,
		input logic uok, input logic sel);
		@(posedge clk);
		#1;
		i_card_term_model.idle();
		file_struct = st;
		file_rec_count = cnt;
		read_access_ok = rok;
		update_access_ok = uok;
		file_selected = sel;
	endtask
	task automatic cmd(input op_t op, input logic [7:0] p1, input logic [7:0] p2,
		input logic [7:0] le, input logic raw, input result_t res, input logic [7:0] len,
		input logic acc, input logic [14:0] off = 15'h0000, input logic [7:0] rec = 8'h00,
		input logic [7:0] ptr = 8'h00, input logic pset = 1'b0);
		exp_t x;
		logic b;
		b = (op == OP_READ_BIN) || (op == OP_UPDATE_BIN);
		x = '{res, len, acc & (op inside {OP_READ_BIN, OP_READ_REC}),
			acc & (op inside {OP_UPDATE_BIN, OP_UPDATE_REC}), (op == OP_STATUS) && (res == RES_OK),
			off, rec, ptr, pset, b ? (p1[7:5] == P1_SFI_TAG) : (p2[7:3] != SFI_CURRENT),
			b ? p1[4:0] : p2[7:3], b};
		@(posedge clk);
		#1;
		file_selected = 1'b0;
		q.push_back(x);
		i_card_term_model.put(op, p1, p2, le, raw);
	endtask
	// ==========================================================
	// Scenarios
	initial begin
		void'($urandom(32'h731d6e89));
		repeat (5) @(posedge clk);
		#1;
		rst_b = 1'b1;
		check("rec_pointer_set", 16'(rec_pointer_set), 16'h0000);
		set_file(FS_TRANSPARENT, 8'h01, 1'b1, 1'b1, 1'b0);
		cmd(OP_STATUS, 8'h00, 8'h00, 8'h20, 1'b0, RES_OK, 8'h20, 1'b0);
		cmd(OP_STATUS, 8'h00, 8'h01, 8'h20, 1'b1, RES_BAD_PARAM, 8'h00, 1'b0);
		for (int i = 0; i < 4; i++) begin
			r1 = 8'($urandom);
			r2 = 8'($urandom);
			cmd(OP_READ_BIN, {1'b0, r1[6:0]}, r2, r1, 1'b0, RES_OK, r1, 1'b1, {r1[6:0], r2});
			cmd(OP_UPDATE_BIN, {P1_SFI_TAG, r1[4:0]}, r2, 8'h00, 1'b0, RES_OK, 8'h00, 1'b1,
				{7'h00, r2});
		end
		cmd(OP_READ_BIN, 8'hA0, 8'h00, 8'h04, 1'b0, RES_BAD_PARAM, 8'h00, 1'b0);
		set_file(FS_TRANSPARENT, 8'h01, 1'b0, 1'b0, 1'b0);
		cmd(OP_READ_BIN, 8'h01, 8'h00, 8'h04, 1'b0, RES_DENIED, 8'h00, 1'b0);
		cmd(OP_UPDATE_BIN, 8'h01, 8'h00, 8'h00, 1'b0, RES_DENIED, 8'h00, 1'b0);
		set_file(FS_LINEAR, 8'h03, 1'b1, 1'b1, 1'b0);
		cmd(OP_READ_BIN, 8'h01, 8'h00, 8'h04, 1'b0, RES_WRONG_STRUCT, 8'h00, 1'b0);
		cmd(OP_UPDATE_BIN, 8'h01, 8'h00, 8'h00, 1'b0, RES_WRONG_STRUCT, 8'h00, 1'b0);
		$display("test binary done");
		set_file(FS_LINEAR, 8'h03, 1'b1, 1'b1, 1'b1);
		cmd(OP_READ_REC, 8'h00, 8'h02, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h00, 8'h01, 1);
		cmd(OP_READ_REC, 8'h00, 8'h02, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h01, 8'h02, 1);
		cmd(OP_READ_REC, 8'h00, 8'h02, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h02, 8'h03, 1);
		cmd(OP_READ_REC, 8'h00, 8'h02, 8'h08, 0, RES_NO_RECORD, 0, 0, 0, 0, 8'h03, 1);
		cmd(OP_READ_REC, 8'h00, 8'h03, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h01, 8'h02, 1);
		cmd(OP_READ_REC, 8'h03, 8'h04, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h02, 8'h02, 1);
		cmd(OP_READ_REC, 8'h00, 8'h04, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h01, 8'h02, 1);
		cmd(OP_READ_REC, 8'h04, 8'h04, 8'h08, 0, RES_NO_RECORD, 0, 0, 0, 0, 8'h02, 1);
		cmd(OP_READ_REC, 8'h00, 8'h00, 8'h08, 0, RES_BAD_PARAM, 0, 0, 0, 0, 8'h02, 1);
		cmd(OP_READ_REC, 8'h00, 8'hFA, 8'h08, 0, RES_BAD_PARAM, 0, 0, 0, 0, 8'h02, 1);
		cmd(OP_UPDATE_REC, 8'h05, 8'h02, 0, 1, RES_OK, 0, 1, 0, 8'h02, 8'h03, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h02, 0, 0, RES_NO_RECORD, 0, 0, 0, 0, 8'h03, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h03, 0, 0, RES_OK, 0, 1, 0, 8'h01, 8'h02, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h03, 0, 0, RES_OK, 0, 1, 0, 8'h00, 8'h01, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h03, 0, 0, RES_NO_RECORD, 0, 0, 0, 0, 8'h01, 1);
		cmd(OP_READ_REC, 8'h00, 8'h03, 8'h08, 0, RES_NO_RECORD, 0, 0, 0, 0, 8'h01, 1);
		set_file(FS_LINEAR, 8'h03, 1'b0, 1'b0, 1'b0);
		cmd(OP_READ_REC, 8'h00, 8'h02, 8'h08, 0, RES_DENIED, 0, 0, 0, 0, 8'h01, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h02, 0, 0, RES_DENIED, 0, 0, 0, 0, 8'h01, 1);
		set_file(FS_LINEAR, 8'h03, 1'b1, 1'b1, 1'b1);
		file_rec_len = 8'($urandom);
		cmd(OP_READ_REC, 8'h00, 8'h03, 8'h08, 0, RES_OK, file_rec_len, 1, 0, 8'h02, 8'h03, 1);
		cmd(OP_READ_REC, 8'h00, 8'h3A, 8'h08, 0, RES_OK, file_rec_len, 1, 0, 8'h00, 8'h01, 1);
		$display("test linear done");
		set_file(FS_CYCLIC, 8'h04, 1'b1, 1'b1, 1'b1);
		file_rec_len = 8'h08;
		cmd(OP_READ_REC, 8'h00, 8'h02, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h00, 8'h01, 1);
		cmd(OP_READ_REC, 8'h00, 8'h03, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h03, 8'h04, 1);
		cmd(OP_READ_REC, 8'h00, 8'h02, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h00, 8'h01, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h02, 0, 0, RES_NOT_ALLOWED, 0, 0, 0, 0, 8'h01, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h03, 0, 0, RES_OK, 0, 1, 0, 8'h03, 8'h01, 1);
		cmd(OP_READ_REC, 8'h02, 8'h04, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h00, 8'h01, 1);
		cmd(OP_READ_REC, 8'h00, 8'h04, 8'h08, 0, RES_OK, 8'h08, 1, 0, 8'h03, 8'h01, 1);
		cmd(OP_UPDATE_REC, 8'h00, 8'h03, 0, 0, RES_OK, 0, 1, 0, 8'h02, 8'h01, 1);
		set_file(FS_CYCLIC, 8'h04, 1'b1, 1'b0, 1'b0);
		cmd(OP_UPDATE_REC, 8'h00, 8'h03, 0, 0, RES_DENIED, 0, 0, 0, 0, 8'h01, 1);
		set_file(FS_CYCLIC, 8'h04, 1'b1, 1'b1, 1'b0);
		repeat (3) @(posedge clk);
		check("pending", 16'(q.size()), 16'h0000);
		$display("test cyclic done");
		close_out();
	end
endmodule // tb
`default_nettype wire
